// *** hw/psad_gate.sv ***
`timescale 1ns/1ps
module psad_gate (
    psad_gate_if.checker_side g
);
    logic upper;
    logic table_op;

    always_comb begin
        upper         = g.addr[23];
        table_op      = (g.op != psad_pkg::PSAD_IDLE);
        // Upper half needs a table operation with the page bit set
        g.allow       = !upper || (table_op && g.page[psad_pkg::PAGE_UPPER_BIT]); // RULE_05 RULE_06
        g.implemented = !upper && (g.addr <= psad_pkg::IMPL_LAST); // RULE_07
        g.reset_entry = (g.addr == psad_pkg::RESET_JUMP_LO) || (g.addr == psad_pkg::RESET_JUMP_HI); // RULE_07
    end
endmodule : psad_gate

// *** hw/psad_top.sv ***
`timescale 1ns/1ps
module psad_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        fetch_req_i,
    input  wire logic [22:0] pc_i,
    input  wire logic [1:0]  tbl_op_i,
    input  wire logic [7:0]  table_page_reg_i,
    input  wire logic [15:0] tbl_offset_i,
    input  wire logic        remap_req_i,
    input  wire logic [23:0] remap_addr_i,
    input  wire logic [23:0] mem_fetch_data_i,
    input  wire logic [23:0] mem_data_data_i,
    output logic             fetch_en_o,
    output logic [23:0]      fetch_addr_o,
    output logic             fetch_valid_o,
    output logic [23:0]      fetch_word_o,
    output logic             data_en_o,
    output logic             data_we_o,
    output logic [23:0]      data_addr_o,
    output logic             data_valid_o,
    output logic [23:0]      data_word_o,
    output logic             data_err_o
);
    // -------------------------------------------------------------------------
    // Address formation
    // -------------------------------------------------------------------------
    logic [23:0] fetch_addr_c;
    logic [23:0] data_addr_c;
    logic [1:0]  data_op_c;

    always_comb begin
        fetch_addr_c = {1'b0, pc_i}; // RULE_04
        if (tbl_op_i != psad_pkg::PSAD_IDLE) begin
            data_addr_c = {table_page_reg_i, tbl_offset_i}; // RULE_04
            data_op_c   = tbl_op_i;
        end else if (remap_req_i) begin
            data_addr_c = remap_addr_i; // RULE_04
            data_op_c   = psad_pkg::PSAD_IDLE;
        end else begin
            data_addr_c = psad_pkg::ZERO_WORD;
            data_op_c   = psad_pkg::PSAD_IDLE;
        end
    end

    psad_gate_if fg ();
    psad_gate_if dg ();

    assign fg.addr = fetch_addr_c;
    assign fg.op   = psad_pkg::PSAD_IDLE;
    assign fg.page = table_page_reg_i;
    assign dg.addr = data_addr_c;
    assign dg.op   = data_op_c;
    assign dg.page = table_page_reg_i;

    // Two checkers so fetch and data never share a path
    psad_gate u_fetch_gate (.g(fg)); // RULE_01
    psad_gate u_data_gate  (.g(dg)); // RULE_01

    logic data_req_c;
    assign data_req_c = (tbl_op_i != psad_pkg::PSAD_IDLE) || remap_req_i;

    // -------------------------------------------------------------------------
    // Request stage
    // -------------------------------------------------------------------------
    logic        next_fetch_en;
    logic [23:0] next_fetch_addr;
    logic        next_data_en;
    logic        next_data_we;
    logic [23:0] next_data_addr;
    logic        next_data_err;
    logic        f_impl;
    logic        f_reset;
    logic        d_pend;
    logic        d_impl;
    logic        d_upper;
    logic        next_f_impl;
    logic        next_f_reset;
    logic        next_d_pend;
    logic        next_d_impl;
    logic        next_d_upper;

    always_comb begin
        next_fetch_en   = fetch_req_i;
        next_fetch_addr = fetch_addr_c;
        next_f_impl     = fg.implemented;
        next_f_reset    = fg.reset_entry;
        next_d_pend     = data_req_c && dg.allow && (data_op_c != psad_pkg::PSAD_WRITE);
        next_data_en    = data_req_c && dg.allow; // RULE_02 RULE_05 RULE_06
        next_data_we    = data_req_c && dg.allow && (data_op_c == psad_pkg::PSAD_WRITE);
        next_data_addr  = data_addr_c; // RULE_03
        next_data_err   = data_req_c && !dg.allow; // RULE_05
        next_d_impl     = dg.implemented;
        next_d_upper    = data_addr_c[23];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fetch_en_o   <= 1'b0;
            fetch_addr_o <= psad_pkg::ZERO_WORD;
            data_en_o    <= 1'b0;
            data_we_o    <= 1'b0;
            data_addr_o  <= psad_pkg::ZERO_WORD;
            data_err_o   <= 1'b0;
            f_impl       <= 1'b0;
            f_reset      <= 1'b0;
            d_pend       <= 1'b0;
            d_impl       <= 1'b0;
            d_upper      <= 1'b0;
        end else begin
            fetch_en_o   <= next_fetch_en;
            fetch_addr_o <= next_fetch_addr;
            data_en_o    <= next_data_en;
            data_we_o    <= next_data_we;
            data_addr_o  <= next_data_addr;
            data_err_o   <= next_data_err;
            f_impl       <= next_f_impl;
            f_reset      <= next_f_reset;
            d_pend       <= next_d_pend;
            d_impl       <= next_d_impl;
            d_upper      <= next_d_upper;
        end
    end

    // -------------------------------------------------------------------------
    // Return stage
    // -------------------------------------------------------------------------
    logic        next_fetch_valid;
    logic [23:0] next_fetch_word;
    logic        next_data_valid;
    logic [23:0] next_data_word;

    always_comb begin
        next_fetch_valid = fetch_en_o;
        if (f_reset && (fetch_addr_o == psad_pkg::RESET_JUMP_LO)) begin
            next_fetch_word = psad_pkg::JUMP_OPCODE; // RULE_07
        end else if (f_reset) begin
            next_fetch_word = {9'h000, psad_pkg::RESET_TARGET_HI}; // RULE_07
        end else if (f_impl) begin
            next_fetch_word = mem_fetch_data_i;
        end else begin
            next_fetch_word = psad_pkg::ZERO_WORD; // RULE_07
        end
        next_data_valid = d_pend;
        next_data_word  = (d_impl || d_upper) ? mem_data_data_i : psad_pkg::ZERO_WORD; // RULE_07
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fetch_valid_o <= 1'b0;
            fetch_word_o  <= psad_pkg::ZERO_WORD;
            data_valid_o  <= 1'b0;
            data_word_o   <= psad_pkg::ZERO_WORD;
        end else begin
            fetch_valid_o <= next_fetch_valid;
            fetch_word_o  <= next_fetch_word;
            data_valid_o  <= next_data_valid;
            data_word_o   <= next_data_word;
        end
    end

    // -------------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------------
    property p_fetch_lower;
        @(posedge clk_i) disable iff (rst_i) fetch_en_o |-> !fetch_addr_o[23];
    endproperty
    a_fetch_lower: assert property (p_fetch_lower) else $error("fetch reached upper half"); // RULE_05

    property p_upper_needs_page;
        @(posedge clk_i) disable iff (rst_i)
            (data_req_c && data_addr_c[23]
             && !(tbl_op_i != psad_pkg::PSAD_IDLE && table_page_reg_i[psad_pkg::PAGE_UPPER_BIT]))
            |=> !data_en_o && data_err_o;
    endproperty
    a_upper_needs_page: assert property (p_upper_needs_page) else $error("upper half opened without page"); // RULE_06

    property p_lower_granted;
        @(posedge clk_i) disable iff (rst_i) (data_req_c && !data_addr_c[23]) |=> data_en_o && !data_err_o;
    endproperty
    a_lower_granted: assert property (p_lower_granted) else $error("lower access refused"); // RULE_02

    property p_addr_form;
        @(posedge clk_i) disable iff (rst_i)
            (tbl_op_i != psad_pkg::PSAD_IDLE) |=> data_addr_o == {$past(table_page_reg_i), $past(tbl_offset_i)};
    endproperty
    a_addr_form: assert property (p_addr_form) else $error("table address wrong"); // RULE_04

    property p_fetch_two;
        @(posedge clk_i) disable iff (rst_i) fetch_req_i |-> ##2 fetch_valid_o;
    endproperty
    a_fetch_two: assert property (p_fetch_two) else $error("fetch answer late"); // RULE_01

    property p_unimpl_zero;
        @(posedge clk_i) disable iff (rst_i)
            (fetch_req_i && {1'b0, pc_i} > psad_pkg::IMPL_LAST) |-> ##2 fetch_word_o == psad_pkg::ZERO_WORD;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented not zero"); // RULE_07

    property p_reset_jump;
        @(posedge clk_i) disable iff (rst_i)
            (fetch_req_i && {1'b0, pc_i} == psad_pkg::RESET_JUMP_LO) |-> ##2 fetch_word_o == psad_pkg::JUMP_OPCODE;
    endproperty
    a_reset_jump: assert property (p_reset_jump) else $error("reset jump missing"); // RULE_07

    property p_reset_hi_zero;
        @(posedge clk_i) disable iff (rst_i)
            (fetch_req_i && {1'b0, pc_i} == psad_pkg::RESET_JUMP_HI) |-> ##2 fetch_word_o == psad_pkg::ZERO_WORD;
    endproperty
    a_reset_hi_zero: assert property (p_reset_hi_zero) else $error("reset target word not zero"); // RULE_07

    property p_remap_refused;
        @(posedge clk_i) disable iff (rst_i)
            (remap_req_i && tbl_op_i == psad_pkg::PSAD_IDLE && remap_addr_i > psad_pkg::USER_LAST)
            |=> data_err_o && !data_en_o;
    endproperty
    a_remap_refused: assert property (p_remap_refused) else $error("remap reached upper half"); // RULE_05

    property p_write_no_answer;
        @(posedge clk_i) disable iff (rst_i) data_we_o |=> !data_valid_o;
    endproperty
    a_write_no_answer: assert property (p_write_no_answer) else $error("write produced a read answer"); // RULE_02

    property p_data_read_valid;
        @(posedge clk_i) disable iff (rst_i) (data_en_o && !data_we_o) |=> data_valid_o;
    endproperty
    a_data_read_valid: assert property (p_data_read_valid) else $error("data read lost"); // RULE_03

    c_parallel: cover property (@(posedge clk_i) disable iff (rst_i) fetch_en_o && data_en_o);
    c_cfg_read: cover property (@(posedge clk_i) disable iff (rst_i) data_en_o && data_addr_o[23]);
    c_refused:  cover property (@(posedge clk_i) disable iff (rst_i) data_err_o);
    c_write:    cover property (@(posedge clk_i) disable iff (rst_i) data_we_o);
    c_stream:   cover property (@(posedge clk_i) disable iff (rst_i) fetch_en_o && fetch_valid_o);
endmodule : psad_top

// *** shared/psad_gate_if.sv ***
`timescale 1ns/1ps
interface psad_gate_if;
    logic [23:0]          addr;
    logic [1:0]           op;
    logic [7:0]           page;
    logic                 allow;
    logic                 implemented;
    logic                 reset_entry;
    modport requester (output addr, output op, output page, input allow, input implemented, input reset_entry);
    modport checker_side (input addr, input op, input page, output allow, output implemented, output reset_entry);
endinterface : psad_gate_if

// *** shared/psad_pkg.sv ***
// What this block does
// RULE_01 - Instruction fetch and data-space access use separate ports and separate address paths.
// RULE_02 - Program memory can be read through the data-space window while fetches continue in parallel.
// RULE_03 - The program space spans 4M instruction words, each reachable by its own address.
// RULE_04 - Every program address is 24 bits, from the 23-bit program counter or from a table or remap path.
// RULE_05 - Ordinary accesses are confined to 0x000000 through 0x7FFFFF.
// RULE_06 - Only table reads and writes with page bit 7 set may reach the upper half.
// RULE_07 - Unimplemented user locations read as zero, and a jump sits at the reset entry ahead of the vectors (the jump is fetch path only).
package psad_pkg;
    localparam int          ADDR_W          = 24;
    localparam int          PC_W            = 23;
    localparam int          WORD_W          = 24;
    localparam int          PAGE_W          = 8;
    localparam int          PAGE_UPPER_BIT  = 7;
    localparam int          SPACE_WORDS     = 4194304;
    localparam logic [23:0] USER_LAST       = 24'h7F_FFFF;
    localparam logic [23:0] IMPL_LAST       = 24'h02_ABFE;
    localparam logic [23:0] RESET_JUMP_LO   = 24'h00_0000;
    localparam logic [23:0] RESET_JUMP_HI   = 24'h00_0002;
    localparam logic [23:0] VECTOR_FIRST    = 24'h00_0004;
    localparam logic [23:0] JUMP_OPCODE     = 24'h04_0200;
    localparam logic [23:0] ZERO_WORD       = 24'h00_0000;
    localparam logic [14:0] RESET_TARGET_HI = 15'h0000;

    typedef enum logic [1:0] {
        PSAD_IDLE  = 2'b00,
        PSAD_READ  = 2'b01,
        PSAD_WRITE = 2'b11
    } psad_op_t;
endpackage : psad_pkg

// *** test/psad_mem_model.sv ***
`timescale 1ns/1ps
module psad_mem_model (
    input  wire logic        fetch_en_i,
    input  wire logic [23:0] fetch_addr_i,
    input  wire logic        data_en_i,
    input  wire logic [23:0] data_addr_i,
    output logic      [23:0] fetch_data_o,
    output logic      [23:0] data_data_o
);
    // ------------------------------------------------------------
    // Two separate read ports; a deselected port shows the inverse
    // ------------------------------------------------------------
    assign fetch_data_o = fetch_en_i ? fetch_addr_i ^ 24'h5A_A5C3 : ~(fetch_addr_i ^ 24'h5A_A5C3);
    assign data_data_o  = data_en_i ? data_addr_i ^ 24'h5A_A5C3 : ~(data_addr_i ^ 24'h5A_A5C3);
endmodule : psad_mem_model

// *** test/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    logic        clk_i            = 1'b0;
    logic        rst_i            = 1'b1;
    logic        fetch_req_i      = 1'b0;
    logic [22:0] pc_i             = 23'h00_0000;
    logic [1:0]  tbl_op_i         = 2'b00;
    logic [7:0]  table_page_reg_i = 8'h00;
    logic [15:0] tbl_offset_i     = 16'h0000;
    logic        remap_req_i      = 1'b0;
    logic [23:0] remap_addr_i     = 24'h00_0000;
    logic [23:0] mem_fetch_data_i, mem_data_data_i, fetch_addr_o, fetch_word_o, data_addr_o, data_word_o;
    logic        fetch_en_o, fetch_valid_o, data_en_o, data_we_o, data_valid_o, data_err_o;
    int          n_mismatch       = 0;
    int          samples_checked  = 0;

    always #2 clk_i = ~clk_i;

    psad_top i_dut (.clk_i, .rst_i, .fetch_req_i, .pc_i, .tbl_op_i, .table_page_reg_i, .tbl_offset_i,
        .remap_req_i, .remap_addr_i, .mem_fetch_data_i, .mem_data_data_i, .fetch_en_o, .fetch_addr_o,
        .fetch_valid_o, .fetch_word_o, .data_en_o, .data_we_o, .data_addr_o, .data_valid_o, .data_word_o,
        .data_err_o);
    psad_mem_model i_mem (.fetch_en_i(fetch_en_o), .fetch_addr_i(fetch_addr_o), .data_en_i(data_en_o),
        .data_addr_i(data_addr_o), .fetch_data_o(mem_fetch_data_i), .data_data_o(mem_data_data_i));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [23:0] mf(input logic [23:0] a);
        return a ^ 24'h5A_A5C3;
    endfunction : mf

    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test

    task automatic fetch(input logic [22:0] pc);
        logic [23:0] exp;
        exp = mf({1'b0, pc});
        if ({1'b0, pc} == psad_pkg::RESET_JUMP_HI || {1'b0, pc} > psad_pkg::IMPL_LAST) exp = psad_pkg::ZERO_WORD;
        if ({1'b0, pc} == psad_pkg::RESET_JUMP_LO) exp = psad_pkg::JUMP_OPCODE;
        @(negedge clk_i);
        fetch_req_i = 1'b1;
        pc_i = pc;
        @(negedge clk_i);
        fetch_req_i = 1'b0;
        chk({23'h0, fetch_en_o}, 24'h00_0001);
        chk(fetch_addr_o, {1'b0, pc});
        @(negedge clk_i);
        chk({23'h0, fetch_valid_o}, 24'h00_0001);
        chk(fetch_word_o, exp);
    endtask : fetch

    task automatic dacc(input logic [1:0] op, input logic [7:0] pg, input logic [15:0] off, input logic [23:0] ra);
        logic [23:0] a;
        logic        ok;
        logic        rd;
        a = (op != 2'b00) ? {pg, off} : ra;
        ok = !a[23] || (op != 2'b00 && pg[7]);
        rd = ok && op != 2'b11;
        @(negedge clk_i);
        tbl_op_i = op;
        table_page_reg_i = pg;
        tbl_offset_i = off;
        remap_req_i = (op == 2'b00);
        remap_addr_i = ra;
        @(negedge clk_i);
        tbl_op_i = 2'b00;
        remap_req_i = 1'b0;
        chk({22'h0, data_en_o, data_err_o}, {22'h0, ok, !ok});
        chk({23'h0, data_we_o}, {23'h0, ok && op == 2'b11});
        if (ok) chk(data_addr_o, a);
        @(negedge clk_i);
        chk({23'h0, data_valid_o}, {23'h0, rd});
        if (rd) chk(data_word_o, (!a[23] && a > psad_pkg::IMPL_LAST) ? 24'h0 : mf(a));
    endtask : dacc

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        @(negedge clk_i);
        rst_i = 1'b1;
        fetch_req_i = 1'b1;
        tbl_op_i = 2'b01;
        repeat (2) @(negedge clk_i);
        chk({18'h0, fetch_en_o, fetch_valid_o, data_en_o, data_valid_o, data_err_o, data_we_o}, 24'h0);
        chk(fetch_addr_o, 24'h00_0000);
        chk(fetch_word_o, 24'h00_0000);
        chk(data_addr_o, 24'h00_0000);
        chk(data_word_o, 24'h00_0000);
        rst_i = 1'b0;
        fetch_req_i = 1'b0;
        tbl_op_i = 2'b00;
        @(negedge clk_i);
        chk({18'h0, fetch_en_o, fetch_valid_o, data_en_o, data_valid_o, data_err_o, data_we_o}, 24'h0);
        $display("Test reset done");
    endtask : t_reset

    task automatic t_fetch();
        logic [22:0] pcs [6] = '{23'h00_0000, 23'h00_0002, 23'h00_0004, 23'h02_ABFE, 23'h02_AC00, 23'h7F_FFFF};
        foreach (pcs[i]) fetch(pcs[i]);
        $display("Test fetch done");
    endtask : t_fetch

    task automatic t_data();
        dacc(2'b01, 8'h00, 16'h1234, 24'h0);
        dacc(2'b01, 8'h02, 16'hAC00, 24'h0);
        dacc(2'b01, 8'h80, 16'h0000, 24'h0);
        dacc(2'b11, 8'hFF, 16'h0000, 24'h0);
        dacc(2'b11, 8'h00, 16'h0200, 24'h0);
        dacc(2'b00, 8'h00, 16'h0000, 24'h00_0100);
        dacc(2'b00, 8'h00, 16'h0000, 24'h80_0000);
        dacc(2'b00, 8'h00, 16'h0000, 24'hFF_0000);
        $display("Test data done");
    endtask : t_data

    task automatic t_both();
        fork
            fetch(23'h00_0300);
            dacc(2'b01, 8'h00, 16'h0400, 24'h0);
        join
        $display("Test concurrent done");
    endtask : t_both

    // Back to back fetches while a table read and a remap request arrive together
    task automatic t_burst();
        @(negedge clk_i);
        fetch_req_i = 1'b1;
        pc_i = 23'h00_0000;
        tbl_op_i = 2'b01;
        table_page_reg_i = 8'h00;
        tbl_offset_i = 16'h0300;
        remap_req_i = 1'b1;
        remap_addr_i = 24'h80_0000;
        @(negedge clk_i);
        pc_i = 23'h00_0400;
        tbl_op_i = 2'b00;
        remap_req_i = 1'b0;
        chk(fetch_addr_o, 24'h00_0000);
        chk({22'h0, data_en_o, data_err_o}, 24'h00_0002);
        chk(data_addr_o, 24'h00_0300);
        @(negedge clk_i);
        fetch_req_i = 1'b0;
        chk({22'h0, fetch_en_o, fetch_valid_o}, 24'h00_0003);
        chk(fetch_addr_o, 24'h00_0400);
        chk(fetch_word_o, psad_pkg::JUMP_OPCODE);
        chk({23'h0, data_valid_o}, 24'h00_0001);
        chk(data_word_o, mf(24'h00_0300));
        @(negedge clk_i);
        chk({22'h0, fetch_en_o, fetch_valid_o}, 24'h00_0001);
        chk(fetch_word_o, mf(24'h00_0400));
        $display("Test burst done");
    endtask : t_burst

    initial begin
        repeat (8) @(negedge clk_i);
        rst_i = 1'b0;
        t_fetch();
        t_data();
        t_both();
        t_burst();
        t_reset();
        t_fetch();
        end_of_test();
    end
endmodule : tb_top
